// >>> verilog/onchip_memory_map_decoder.sv
// on-chip memory map decoder with mapping registers and avalon slave
//------------------------------------------------------------------
// Summary of operation
// - rom array present only when enabled
// - rom upper half, or lower in expanded
// - boot rom at be40-bfff in bootstrap
// - bootstrap reset vector fetched from boot rom
// - boot rom disabled in normal modes
// - register block 128 bytes at 0000 after reset
// - register block relocatable to any 4k page
// - map register at 3d, ram/reg nibbles, reset zero
// - priority register at 3c, flags and select
// - stop halts clocks, ram untouched
// - shared page: ram at 080, alias 400-47f
// - eeprom at d80, page movable
// - test clears rom enable, single forces high
//------------------------------------------------------------------
`timescale 1ns/1ps

module onchip_memory_map_decoder (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // mode straps and configuration byte
    input wire logic mode_a_pin,
    input wire logic mode_select_b_standby_pin,
    input wire logic cfg_rom_array_on,
    input wire logic cfg_rom_high_placement,
    input wire logic cfg_eeprom_on,
    // stop control
    input wire logic stop_req,
    input wire logic wake_req,
    output logic clk_run,
    // cpu bus
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_rd,
    input wire logic cpu_wr,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic ext_sel,
    // peripheral register strobes
    output logic periph_sel,
    output logic [6:0] periph_addr,
    input wire logic [7:0] periph_rdata,
    // memory arrays
    output logic ram_sel,
    output logic ram_we,
    output logic [9:0] ram_addr,
    input wire logic [7:0] ram_rdata,
    output logic ee_sel,
    output logic [9:0] ee_addr,
    input wire logic [7:0] ee_rdata,
    output logic rom_sel,
    output logic [14:0] rom_addr,
    input wire logic [7:0] rom_rdata,
    output logic boot_sel,
    output logic [8:0] boot_addr,
    input wire logic [7:0] boot_rdata,
    // avalon-mm register slave
    input wire logic [8:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);
    import memmap_pkg::*;

    phase_type phase_r;
    mode_type mode;
    src_type src_r;
    src_type src_nxt;
    logic [7:0] map_r;
    logic [7:0] ee_page_r;
    logic [4:0] psel_r;
    logic boot_flag_r;
    logic special_mode_flag_r;
    logic mda_r;
    logic rom_on_r;
    logic rom_high_r;
    logic ee_on_r;
    logic ack_r;
    logic [7:0] cpu_rdata_r;
    logic [31:0] avs_rdata_r;
    logic run;
    logic reg_hit;
    logic ram_hit;
    logic ee_hit;
    logic boot_hit;
    logic rom_hit;
    logic [11:0] off;
    logic [6:0] avs_idx;
    logic avs_wr_go;
    logic cpu_reg_wr;
    logic prio_av;

    // returns the register contents at a block index, zero elsewhere
    function automatic logic [7:0] reg_read(input logic [6:0] idx);
        unique case (idx)
            EE_PAGE_IDX: reg_read = ee_page_r;
            PRIO_IDX: reg_read = {boot_flag_r, special_mode_flag_r, mda_r, psel_r};
            MAP_IDX: reg_read = map_r;
            default: reg_read = 8'h00;
        endcase
    endfunction

    function automatic logic is_own(input logic [6:0] idx);
        is_own = (idx == EE_PAGE_IDX) || (idx == PRIO_IDX) || (idx == MAP_IDX);
    endfunction

    //------------------------------------------------------------------
    // operating phase and mode
    //------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            phase_r <= PH_STRAP;
        end else begin
            unique case (phase_r)
                PH_STRAP: phase_r <= PH_RUN;
                PH_RUN: if (stop_req) phase_r <= PH_STOP;
                PH_STOP: if (wake_req) phase_r <= PH_RUN;
            endcase
        end
    end

    always_comb begin
        unique case ({special_mode_flag_r, mda_r})
            2'b00: mode = MODE_SINGLE;
            2'b01: mode = MODE_EXPANDED;
            2'b10: mode = MODE_BOOT;
            2'b11: mode = MODE_TEST;
        endcase
    end

    // internal clocks halt while stopped; array contents are never written then
    assign run = (phase_r == PH_RUN);
    assign clk_run = run;

    //------------------------------------------------------------------
    // configuration capture at reset release
    //------------------------------------------------------------------
    // straps are sampled by the clock after release, never by the reset itself
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rom_on_r <= 1'b0;
            rom_high_r <= 1'b0;
            ee_on_r <= 1'b0;
        end else if (phase_r == PH_STRAP) begin
            rom_on_r <= cfg_rom_array_on & ~(~mode_select_b_standby_pin & mode_a_pin);
            rom_high_r <= cfg_rom_high_placement
                | (mode_select_b_standby_pin & ~mode_a_pin);
            ee_on_r <= cfg_eeprom_on;
        end
    end

    //------------------------------------------------------------------
    // mapping and priority registers
    //------------------------------------------------------------------
    assign avs_idx = avs_address[8:AVS_IDX_LSB];
    assign avs_wr_go = avs_write & ack_r & avs_byteenable[0];
    assign cpu_reg_wr = cpu_wr & reg_hit & run;
    assign prio_av = avs_wr_go && (avs_idx == PRIO_IDX);

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            map_r <= MAP_RST;
            ee_page_r <= EE_PAGE_RST;
        end else if (avs_wr_go) begin
            if (avs_idx == MAP_IDX) map_r <= avs_writedata[7:0];
            if (avs_idx == EE_PAGE_IDX) ee_page_r <= avs_writedata[7:0];
        end else if (cpu_reg_wr) begin
            if (off[6:0] == MAP_IDX) map_r <= cpu_wdata;
            if (off[6:0] == EE_PAGE_IDX) ee_page_r <= cpu_wdata;
        end
    end

    // mode flags load from the straps; software may change them only in special modes
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            psel_r <= PSEL_RST;
            boot_flag_r <= 1'b0;
            special_mode_flag_r <= 1'b0;
            mda_r <= 1'b0;
        end else if (phase_r == PH_STRAP) begin
            psel_r <= PSEL_RST;
            boot_flag_r <= ~mode_select_b_standby_pin & ~mode_a_pin;
            special_mode_flag_r <= ~mode_select_b_standby_pin;
            mda_r <= mode_a_pin;
        end else if (prio_av || (cpu_reg_wr && off[6:0] == PRIO_IDX)) begin
            psel_r <= prio_av ? avs_writedata[4:0] : cpu_wdata[4:0];
            if (special_mode_flag_r) begin
                boot_flag_r <= prio_av ? avs_writedata[BOOT_BIT] : cpu_wdata[BOOT_BIT];
                special_mode_flag_r <= prio_av ? avs_writedata[SPECIAL_MODE_FLAG_BIT] : cpu_wdata[SPECIAL_MODE_FLAG_BIT];
                mda_r <= prio_av ? avs_writedata[MDA_BIT] : cpu_wdata[MDA_BIT];
            end
        end
    end

    //------------------------------------------------------------------
    // address decode
    //------------------------------------------------------------------
    assign off = cpu_addr[11:0];

    always_comb begin
        reg_hit = run && (cpu_addr[15:12] == map_r[REG_FLD_LSB +: 4])
            && (off <= REG_END);
        ram_hit = run && (cpu_addr[15:12] == map_r[RAM_FLD_LSB +: 4])
            && ((off <= RAM_END)
            || ((map_r[RAM_FLD_LSB +: 4] == map_r[REG_FLD_LSB +: 4])
            && (off >= RAM_ALIAS_LO) && (off <= RAM_ALIAS_HI)));
        ee_hit = run && ee_on_r && (cpu_addr[15:12] == ee_page_r[EE_FLD_LSB +: 4])
            && (off >= EE_LO);
        // vectors are served by the boot rom so reset starts the bootloader
        boot_hit = run && boot_flag_r && (mode == MODE_BOOT)
            && (((cpu_addr >= BOOT_LO) && (cpu_addr <= BOOT_HI))
            || (cpu_addr >= VEC_LO));
        rom_hit = run && rom_on_r && (rom_high_r ? (cpu_addr[15] == ROM_HIGH_BASE[15])
            : ((mode == MODE_EXPANDED || mode == MODE_TEST)
            && cpu_addr[15] == ROM_LOW_BASE[15]));
    end

    // one source only: register block, ram, eeprom, boot rom, rom
    always_comb begin
        if (reg_hit) begin
            src_nxt = is_own(off[6:0]) ? SRC_REG : SRC_PERIPH;
        end else if (ram_hit) begin
            src_nxt = SRC_RAM;
        end else if (ee_hit) begin
            src_nxt = SRC_EE;
        end else if (boot_hit) begin
            src_nxt = SRC_BOOT;
        end else if (rom_hit) begin
            src_nxt = SRC_ROM;
        end else begin
            src_nxt = SRC_NONE;
        end
    end

    assign periph_sel = (src_nxt == SRC_PERIPH);
    assign periph_addr = off[6:0];
    assign ram_sel = (src_nxt == SRC_RAM);
    assign ram_we = ram_sel & cpu_wr;
    assign ram_addr = (off >= RAM_ALIAS_LO) ? {3'h0, off[6:0]} : off[9:0];
    assign ee_sel = (src_nxt == SRC_EE);
    assign ee_addr = 10'(off - EE_LO);
    assign boot_sel = (src_nxt == SRC_BOOT);
    assign boot_addr = (cpu_addr >= VEC_LO) ? {BOOT_HI[8:6], cpu_addr[5:0]}
        : cpu_addr[8:0];
    assign rom_sel = (src_nxt == SRC_ROM);
    assign rom_addr = cpu_addr[14:0];
    assign ext_sel = run && (src_nxt == SRC_NONE) && (mode == MODE_EXPANDED || mode == MODE_TEST);

    //------------------------------------------------------------------
    // cpu read data: one cycle for the arrays, one for the output register
    //------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            src_r <= SRC_NONE;
        end else begin
            src_r <= cpu_rd ? src_nxt : SRC_NONE;
        end
    end

    logic [6:0] rd_idx_r;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rd_idx_r <= 7'h00;
        end else begin
            rd_idx_r <= off[6:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cpu_rdata_r <= 8'h00;
        end else begin
            unique case (src_r)
                SRC_REG: cpu_rdata_r <= reg_read(rd_idx_r);
                SRC_PERIPH: cpu_rdata_r <= periph_rdata;
                SRC_RAM: cpu_rdata_r <= ram_rdata;
                SRC_EE: cpu_rdata_r <= ee_rdata;
                SRC_BOOT: cpu_rdata_r <= boot_rdata;
                SRC_ROM: cpu_rdata_r <= rom_rdata;
                SRC_NONE: cpu_rdata_r <= 8'h00;
            endcase
        end
    end
    assign cpu_rdata = cpu_rdata_r;

    //------------------------------------------------------------------
    // avalon slave: one wait state per access
    //------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (avs_read | avs_write) & ~ack_r;
        end
    end
    assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            avs_rdata_r <= 32'h0000_0000;
        end else if (avs_read && !ack_r) begin
            avs_rdata_r <= {24'h00_0000, reg_read(avs_idx)};
        end
    end
    assign avs_readdata = avs_rdata_r;

    //------------------------------------------------------------------
    // assertions
    //------------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    AST_ROM_ABSENT: assert property (!rom_on_r |-> !rom_sel)
        else $error("rom selected while disabled");
    AST_ROM_PLACE: assert property (rom_sel |-> cpu_addr[15] == rom_high_r)
        else $error("rom decoded in wrong half");
    AST_BOOT_RANGE: assert property (boot_sel && cpu_addr < VEC_LO
        |-> cpu_addr >= BOOT_LO && cpu_addr <= BOOT_HI)
        else $error("boot rom outside its window");
    AST_BOOT_VEC: assert property (mode == MODE_BOOT && boot_flag_r && run
        && cpu_addr == 16'hfffe |-> boot_sel && boot_addr == 9'h1fe)
        else $error("reset vector not from boot rom");
    AST_BOOT_NORMAL: assert property (!special_mode_flag_r |-> !boot_sel)
        else $error("boot rom active in normal mode");
    AST_REG_WIN: assert property ((periph_sel || src_nxt == SRC_REG)
        |-> off <= REG_END && cpu_addr[15:12] == map_r[3:0])
        else $error("register block decoded outside its page");
    AST_MAP_WRITE: assert property (avs_wr_go && avs_idx == MAP_IDX
        |=> map_r == $past(avs_writedata[7:0]) ##1 map_r == $past(map_r))
        else $error("map register write lost");
    AST_PRIO_RST: assert property (phase_r == PH_STRAP |=> psel_r == PSEL_RST)
        else $error("priority select reset value wrong");
    AST_STOP: assert property (phase_r == PH_STOP |-> !clk_run && !ram_we
        && !rom_sel && !ram_sel)
        else $error("activity during stop");
    AST_RAM_ALIAS: assert property (ram_sel && off >= RAM_ALIAS_LO
        |-> ram_addr[9:7] == 3'h0 && map_r[7:4] == map_r[3:0])
        else $error("ram alias decoded wrongly");
    AST_EE_PAGE: assert property (ee_sel |-> cpu_addr[15:12] == ee_page_r[7:4]
        && off >= EE_LO)
        else $error("eeprom decoded outside its page");
    AST_TEST_ROM: assert property (phase_r == PH_STRAP && !mode_select_b_standby_pin
        && mode_a_pin |=> !rom_on_r)
        else $error("rom left enabled in test mode");
    AST_ONE_SRC: assert property ($onehot0({periph_sel, ram_sel, ee_sel, boot_sel, rom_sel}))
        else $error("more than one source selected");
    AST_READ_PATH: assert property (cpu_rd && ram_sel
        |=> src_r == SRC_RAM ##1 cpu_rdata_r == $past(ram_rdata))
        else $error("ram read data not returned");

    COV_BOOT_FETCH: cover property (boot_sel && cpu_rd);
    COV_SHARED_PAGE: cover property (ram_sel && off >= RAM_ALIAS_LO);
    COV_RELOCATE: cover property (avs_wr_go && avs_idx == MAP_IDX ##1 map_r != MAP_RST);
    COV_STOP_WAKE: cover property (phase_r == PH_STOP ##1 phase_r == PH_RUN);

endmodule // onchip_memory_map_decoder

// >>> inc/memmap_pkg.sv
// constants and types for the on-chip memory map decoder
package memmap_pkg;
    // register block offsets (index); avalon byte address is index * 4
    localparam logic [6:0] EE_PAGE_IDX = 7'h37;
    localparam logic [6:0] PRIO_IDX = 7'h3c;
    localparam logic [6:0] MAP_IDX = 7'h3d;
    localparam int AVS_IDX_LSB = 2;
    // reset values
    localparam logic [7:0] MAP_RST = 8'h00;
    localparam logic [7:0] EE_PAGE_RST = 8'h00;
    localparam logic [4:0] PSEL_RST = 5'h06;
    // field positions
    localparam int RAM_FLD_LSB = 4;
    localparam int REG_FLD_LSB = 0;
    localparam int EE_FLD_LSB = 4;
    localparam int BOOT_BIT = 7;
    localparam int SPECIAL_MODE_FLAG_BIT = 6;
    localparam int MDA_BIT = 5;
    // address map
    localparam logic [15:0] ROM_HIGH_BASE = 16'h8000;
    localparam logic [15:0] ROM_LOW_BASE = 16'h0000;
    localparam logic [15:0] BOOT_LO = 16'hbe40;
    localparam logic [15:0] BOOT_HI = 16'hbfff;
    localparam logic [15:0] VEC_LO = 16'hffc0;
    localparam logic [11:0] REG_END = 12'h07f;
    localparam logic [11:0] RAM_END = 12'h3ff;
    localparam logic [11:0] RAM_ALIAS_LO = 12'h400;
    localparam logic [11:0] RAM_ALIAS_HI = 12'h47f;
    localparam logic [11:0] EE_LO = 12'hd80;

    typedef enum logic [3:0] {
        MODE_SINGLE = 4'b0001,
        MODE_EXPANDED = 4'b0010,
        MODE_BOOT = 4'b0100,
        MODE_TEST = 4'b1000
    } mode_type;

    typedef enum logic [2:0] {
        PH_STRAP = 3'b001,
        PH_RUN = 3'b010,
        PH_STOP = 3'b100
    } phase_type;

    typedef enum logic [6:0] {
        SRC_NONE = 7'b0000001,
        SRC_REG = 7'b0000010,
        SRC_PERIPH = 7'b0000100,
        SRC_RAM = 7'b0001000,
        SRC_EE = 7'b0010000,
        SRC_BOOT = 7'b0100000,
        SRC_ROM = 7'b1000000
    } src_type;
endpackage

// >>> tb/mem_arrays_model.sv
// behavioural memory arrays and peripheral block answering the decoder
`timescale 1ns/1ps
module mem_arrays_model (
    // clock
    input wire logic clk_sys,
    // selects and addresses from the decoder
    input wire logic ram_sel,
    input wire logic ram_we,
    input wire logic [9:0] ram_addr,
    input wire logic [7:0] wdata,
    input wire logic ee_sel,
    input wire logic [9:0] ee_addr,
    input wire logic rom_sel,
    input wire logic [14:0] rom_addr,
    input wire logic boot_sel,
    input wire logic [8:0] boot_addr,
    input wire logic periph_sel,
    input wire logic [6:0] periph_addr,
    // read data, valid the cycle after a select
    output logic [7:0] ram_rdata,
    output logic [7:0] ee_rdata,
    output logic [7:0] rom_rdata,
    output logic [7:0] boot_rdata,
    output logic [7:0] periph_rdata
);
    logic [7:0] ram_mem [0:1023];
    // unselected arrays toggle so that stale data never passes for valid
    always_ff @(posedge clk_sys) begin
        if (ram_we) ram_mem[ram_addr] <= wdata;
        ram_rdata <= ram_sel ? ram_mem[ram_addr] : ~ram_rdata;
        ee_rdata <= ee_sel ? (ee_addr[7:0] ^ 8'h5a) : ~ee_rdata;
        rom_rdata <= rom_sel ? (rom_addr[7:0] ^ 8'h3c) : ~rom_rdata;
        boot_rdata <= boot_sel ? (boot_addr[7:0] ^ 8'ha5) : ~boot_rdata;
        periph_rdata <= periph_sel ? ({1'b0, periph_addr} ^ 8'hc3) : ~periph_rdata;
    end
endmodule // mem_arrays_model

// >>> tb/tb_top.sv
// self-checking bench for the on-chip memory map decoder
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin n_fail++; \
    $display("ERROR %s expected %h seen %h", nm, ex, got); end end
module tb_top;
    import memmap_pkg::*;
    // select vector {periph, ram, ee, rom, boot, ext}
    localparam logic [5:0] S_P = 6'h20, S_R = 6'h10, S_E = 6'h08;
    localparam logic [5:0] S_O = 6'h04, S_B = 6'h02, S_X = 6'h01, S_0 = 6'h00;
    logic clk_sys = 1'b0, rst_b = 1'b0, mode_a_pin = 1'b0, mode_select_b_standby_pin = 1'b1;
    logic cfg_rom_array_on = 1'b1, cfg_rom_high_placement = 1'b0, cfg_eeprom_on = 1'b1;
    logic stop_req = 1'b0, wake_req = 1'b0, clk_run, cpu_rd = 1'b0, cpu_wr = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0] cpu_wdata = 8'h00, cpu_rdata, periph_rdata, ram_rdata, ee_rdata, rom_rdata;
    logic [7:0] boot_rdata;
    logic ext_sel, periph_sel, ram_sel, ram_we, ee_sel, rom_sel, boot_sel;
    logic [6:0] periph_addr;
    logic [9:0] ram_addr, ee_addr;
    logic [14:0] rom_addr;
    logic [8:0] boot_addr, avs_address = 9'h000;
    logic avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic [3:0] avs_byteenable = 4'h1;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    int n_fail = 0, checks_done = 0;

    always #25 clk_sys = ~clk_sys;

    onchip_memory_map_decoder i_onchip_memory_map_decoder (.clk_sys(clk_sys), .rst_b(rst_b),
        .mode_a_pin(mode_a_pin), .mode_select_b_standby_pin(mode_select_b_standby_pin),
        .cfg_rom_array_on(cfg_rom_array_on), .cfg_rom_high_placement(cfg_rom_high_placement),
        .cfg_eeprom_on(cfg_eeprom_on), .stop_req(stop_req), .wake_req(wake_req),
        .clk_run(clk_run), .cpu_addr(cpu_addr), .cpu_rd(cpu_rd), .cpu_wr(cpu_wr),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .ext_sel(ext_sel),
        .periph_sel(periph_sel), .periph_addr(periph_addr), .periph_rdata(periph_rdata),
        .ram_sel(ram_sel), .ram_we(ram_we), .ram_addr(ram_addr), .ram_rdata(ram_rdata),
        .ee_sel(ee_sel), .ee_addr(ee_addr), .ee_rdata(ee_rdata), .rom_sel(rom_sel),
        .rom_addr(rom_addr), .rom_rdata(rom_rdata), .boot_sel(boot_sel),
        .boot_addr(boot_addr), .boot_rdata(boot_rdata), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_byteenable(avs_byteenable),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest));

    mem_arrays_model i_mem_arrays_model (.clk_sys(clk_sys), .ram_sel(ram_sel),
        .ram_we(ram_we), .ram_addr(ram_addr), .wdata(cpu_wdata), .ee_sel(ee_sel),
        .ee_addr(ee_addr), .rom_sel(rom_sel), .rom_addr(rom_addr), .boot_sel(boot_sel),
        .boot_addr(boot_addr), .periph_sel(periph_sel), .periph_addr(periph_addr),
        .ram_rdata(ram_rdata), .ee_rdata(ee_rdata), .rom_rdata(rom_rdata),
        .boot_rdata(boot_rdata), .periph_rdata(periph_rdata));

    //------------------------------------------------------------------
    // shared tasks
    //------------------------------------------------------------------
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic do_reset(input logic b, input logic a, input logic ron, input logic rhi);
        @(posedge clk_sys);
        rst_b <= 1'b0;
        mode_select_b_standby_pin <= b;
        mode_a_pin <= a;
        cfg_rom_array_on <= ron;
        cfg_rom_high_placement <= rhi;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (2) @(posedge clk_sys);
    endtask

    // one avalon access; request held until waitrequest is seen low at an edge
    task automatic av(input logic [6:0] idx, input logic wr, input logic [7:0] wd,
                      output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk_sys);
        avs_address <= {idx, 2'b00};
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h0, wd};
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            give_verdict();
        end
    endtask

    task automatic cpu_write(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= 1'b1;
        @(posedge clk_sys);
        cpu_wr <= 1'b0;
    endtask

    task automatic reg_is(input logic [6:0] idx, input logic [7:0] mask, input logic [7:0] ex);
        logic [31:0] rd;
        av(idx, 1'b0, 8'h00, rd);
        `CHK("register", {24'h0, ex}, rd & {24'hffffff, mask})
    endtask

    task automatic reg_wr(input logic [6:0] idx, input logic [7:0] wd);
        logic [31:0] rd;
        av(idx, 1'b1, wd, rd);
    endtask

    // decode of one cpu address, read strobe held for one cycle
    task automatic probe(input logic [15:0] a, input logic [5:0] ex);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(negedge clk_sys);
        `CHK("selects", ex, {periph_sel, ram_sel, ee_sel, rom_sel, boot_sel, ext_sel})
        @(posedge clk_sys);
        cpu_rd <= 1'b0;
    endtask

    task automatic rd_data(input logic [15:0] a, input logic [7:0] ex);
        @(posedge clk_sys);
        cpu_addr <= a;
        cpu_rd <= 1'b1;
        @(posedge clk_sys);
        cpu_rd <= 1'b0;
        @(posedge clk_sys);
        @(negedge clk_sys);
        `CHK("cpu_rdata", ex, cpu_rdata)
    endtask

    task automatic pulse(input logic wake);
        @(posedge clk_sys);
        stop_req <= !wake;
        wake_req <= wake;
        @(posedge clk_sys);
        stop_req <= 1'b0;
        wake_req <= 1'b0;
        @(negedge clk_sys);
    endtask

    //------------------------------------------------------------------
    // scenarios
    //------------------------------------------------------------------
    task automatic t_single();
        reg_is(MAP_IDX, 8'hff, 8'h00);
        reg_is(EE_PAGE_IDX, 8'hff, 8'h00);
        reg_is(PRIO_IDX, 8'h7f, 8'h06);
        reg_is(7'h10, 8'hff, 8'h00);
        probe(16'h0000, S_P);
        probe(16'h007f, S_P);
        probe(16'h0080, S_R);
        probe(16'h047f, S_R);
        probe(16'h0d80, S_E);
        probe(16'h8000, S_O);
        probe(16'hbe40, S_O);
        probe(16'h5000, S_0);
        rd_data(16'h0011, 8'h11 ^ 8'hc3);
        rd_data(16'h0d85, 8'h05 ^ 8'h5a);
        rd_data(16'h8012, 8'h12 ^ 8'h3c);
        rd_data(16'h003c, 8'h06);
        $display("test single chip map done");
    endtask

    task automatic t_ram_stop();
        cpu_write(16'h0080, 8'h5c);
        cpu_write(16'h0400, 8'h71);
        rd_data(16'h0080, 8'h5c);
        rd_data(16'h0400, 8'h71);
        pulse(1'b0);
        `CHK("clk_run", 1'b0, clk_run)
        probe(16'h0080, S_0);
        pulse(1'b1);
        `CHK("clk_run", 1'b1, clk_run)
        rd_data(16'h0080, 8'h5c);
        $display("test ram and stop done");
    endtask

    task automatic t_reloc();
        reg_wr(MAP_IDX, 8'h21);
        reg_is(MAP_IDX, 8'hff, 8'h21);
        probe(16'h1000, S_P);
        probe(16'h107f, S_P);
        probe(16'h0000, S_0);
        probe(16'h2000, S_R);
        probe(16'h23ff, S_R);
        rd_data(16'h2000, 8'h71);
        rd_data(16'h2080, 8'h5c);
        rd_data(16'h103d, 8'h21);
        reg_wr(EE_PAGE_IDX, 8'h30);
        probe(16'h3d80, S_E);
        probe(16'h0d80, S_0);
        reg_wr(MAP_IDX, 8'h88);
        reg_wr(EE_PAGE_IDX, 8'h80);
        probe(16'h8000, S_P);
        probe(16'h8080, S_R);
        probe(16'h8400, S_R);
        probe(16'h8480, S_O);
        probe(16'h8d80, S_E);
        cpu_write(16'h803d, 8'h00);
        reg_is(MAP_IDX, 8'hff, 8'h00);
        $display("test relocation done");
    endtask

    task automatic t_modes();
        do_reset(1'b0, 1'b0, 1'b0, 1'b1);
        reg_is(PRIO_IDX, 8'h7f, 8'h46);
        probe(16'hbe40, S_B);
        probe(16'hbfff, S_B);
        probe(16'hbe3f, S_0);
        rd_data(16'hbe41, 8'h41 ^ 8'ha5);
        probe(16'hffc0, S_B);
        rd_data(16'hfffe, 8'hfe ^ 8'ha5);
        do_reset(1'b0, 1'b1, 1'b1, 1'b1);
        reg_is(PRIO_IDX, 8'h7f, 8'h66);
        probe(16'h9000, S_X);
        do_reset(1'b1, 1'b1, 1'b1, 1'b0);
        reg_is(PRIO_IDX, 8'h7f, 8'h26);
        probe(16'h5000, S_O);
        probe(16'h9000, S_X);
        probe(16'hbe40, S_X);
        do_reset(1'b1, 1'b1, 1'b0, 1'b1);
        probe(16'h9000, S_X);
        $display("test operating modes done");
    endtask

    initial begin
        do_reset(1'b1, 1'b0, 1'b1, 1'b0);
        t_single();
        t_ram_stop();
        t_reloc();
        t_modes();
        give_verdict();
    end

    // guard against a hang anywhere in the sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        give_verdict();
    end
endmodule // tb_top
